// File: verification/byte_mask_ctrl_model.sv
/* memory controller model driving the double-rate write pins.
   assumes the port synchronises the clock pins to aclk, needing 3 aclk of setup. */
`timescale 1ns/1ps
module byte_mask_ctrl_model (
   input wire logic aclk,
   output logic main_clk,
   output logic main_clk_b,
   output logic write_port_select_n,
   output logic [3:0] byte_lane_write_select_n,
   output logic [3:0] wr_addr,
   output logic [35:0] wr_data
);
   // ************************************************************
   // one burst of two words
   // ************************************************************
   initial begin
      main_clk = 1'b0;
      main_clk_b = 1'b0;
      write_port_select_n = 1'b1;
      byte_lane_write_select_n = 4'hF;
      wr_addr = 4'h0;
      wr_data = 36'h0;
   end
   task automatic burst(input logic [3:0] a, input logic [35:0] d0, input logic [3:0] s0,
                        input logic [35:0] d1, input logic [3:0] s1);
      @(posedge aclk);
      write_port_select_n <= 1'b0;
      wr_data <= d0;
      byte_lane_write_select_n <= s0;
      repeat (4) @(posedge aclk);
      main_clk <= 1'b1;
      repeat (4) @(posedge aclk);
      wr_data <= d1;
      byte_lane_write_select_n <= s1;
      wr_addr <= a;
      repeat (4) @(posedge aclk);
      main_clk <= 1'b0;
      main_clk_b <= 1'b1;
      repeat (4) @(posedge aclk);
      // stopped clocks rest equal, both low, for a clean restart
      main_clk_b <= 1'b0;
      write_port_select_n <= 1'b1;
      // released pins show no stale word
      wr_data <= ~d1;
      byte_lane_write_select_n <= ~s1;
      wr_addr <= ~a;
      repeat (4) @(posedge aclk);
   endtask : burst
endmodule : byte_mask_ctrl_model

// File: verification/byte_mask_write_port_asserts.sv
/* checker for the bus and buffer-ready ports of the masked write port.
   assumes clk_en stays high and aclk is the only clock. */
`timescale 1ns/1ps
module bm_chk (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic wr_buf_ready,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   // ************************************************************
   // properties
   // ************************************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_idle; $rose(aresetn) |-> wr_buf_ready && !s_axi_bvalid && !s_axi_rvalid; endproperty
   a_idle: assert property (p_idle) else $error("not idle after reset");
   property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write answer dropped early");
   property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read answer dropped early");
   property p_b_time;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid;
   endproperty
   a_b_time: assert property (p_b_time) else $error("write answer late");
   property p_r_time; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_r_time: assert property (p_r_time) else $error("read answer late");
   property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_ar_block: assert property (p_ar_block) else $error("read taken while answering");
   property p_aw_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
   a_aw_block: assert property (p_aw_block) else $error("write taken while answering");
   property p_unmapped; s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h14
      |=> s_axi_rresp == byte_mask_pkg::RESP_SLVERR && s_axi_rdata == 32'h0; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
   property p_ar_back; s_axi_rvalid && s_axi_rready |=> ##1 s_axi_arready; endproperty
   a_ar_back: assert property (p_ar_back) else $error("read ready not restored");
   c_write: cover property (s_axi_bvalid && s_axi_bready);
   c_read: cover property (s_axi_rvalid && s_axi_rready);
   c_full: cover property (!wr_buf_ready);
endmodule : bm_chk

bind byte_mask_write_port bm_chk u_chk (.aclk, .aresetn, .wr_buf_ready, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
   .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
   .s_axi_rready);

// File: verification/testbench.sv
/* self-checking bench: lane masks in both organisations, buffer overflow, bus refusal.
   assumes the controller model and the bound checker. */
`timescale 1ns/1ps
module testbench;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic [7:0] s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic wr_buf_ready, mc, mcb, wps_n;
   logic [1:0] s_axi_bresp, s_axi_rresp, rr, br;
   logic [31:0] s_axi_rdata, rv, cnt;
   logic [3:0] sel_n, addr;
   logic [35:0] data;
   int err_total = 0;
   int comparisons = 0;
   localparam logic [3:0] sel_tab [7] = '{4'h0, 4'hE, 4'hD, 4'hB, 4'h7, 4'hF, 4'hA};

   always #2.5 aclk = ~aclk;

   byte_mask_write_port uut (.aclk(aclk), .aresetn(aresetn), .clk_en(1'b1), .main_clk(mc),
      .main_clk_b(mcb), .write_port_select_n(wps_n), .byte_lane_write_select_n(sel_n),
      .wr_addr(addr), .wr_data(data), .wr_buf_ready(wr_buf_ready),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

   byte_mask_ctrl_model ctrl (.aclk(aclk), .main_clk(mc), .main_clk_b(mcb),
      .write_port_select_n(wps_n), .byte_lane_write_select_n(sel_n), .wr_addr(addr),
      .wr_data(data));

   // ************************************************************
   // bus tasks and comparison
   // ************************************************************
   task automatic results;
      $display("comparisons %0d err_total %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : results

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      br = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd

   // reads back one stored word and compares the lanes that the mode can write
   task automatic cmp_word(input logic [3:0] a, input logic w, input logic [35:0] e,
                           input logic [35:0] m);
      wr(8'h08, {23'h0, w, 4'h0, a});
      rd(8'h0C, rv, rr);
      chk(rv & m[31:0], e[31:0] & m[31:0]);
      rd(8'h10, rv, rr);
      chk({28'h0, rv[3:0] & m[35:32]}, {28'h0, e[35:32] & m[35:32]});
   endtask : cmp_word

   function automatic logic [35:0] merge(logic [35:0] o, logic [35:0] n, logic [3:0] s, int w);
      for (int i = 0; i < 4; i++)
         if (!s[i] && (w == 1 || i < 2)) o[i*9 +: 9] = n[i*9 +: 9];
      return o;
   endfunction : merge

   // ************************************************************
   // tests
   // ************************************************************
   initial begin
      repeat (20000) @(posedge aclk);
      err_total++;
      results();
   end

   initial begin
      logic [35:0] p, q, m;
      logic [3:0] s0, s1;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rd(8'h00, rv, rr);
      chk(rv, 32'h0);
      rd(8'h04, rv, rr);
      chk(rv, 32'h0);
      rd(8'h14, rv, rr);
      chk(rv, 32'h0);
      rd(8'h40, rv, rr);
      chk({30'h0, rr}, {30'h0, byte_mask_pkg::RESP_SLVERR});
      wr(8'h40, 32'h0);
      chk({30'h0, br}, {30'h0, byte_mask_pkg::RESP_SLVERR});
      for (int w = 0; w < 2; w++) begin
         wr(8'h00, w);
         chk({30'h0, br}, {30'h0, byte_mask_pkg::RESP_OKAY});
         m = (w == 1) ? 36'hF_FFFF_FFFF : 36'h0_0003_FFFF;
         for (int i = 0; i < 7; i++) begin
            p = 36'h1_2345_6789 + i;
            q = 36'hE_DCBA_9876 - i;
            s0 = sel_tab[i];
            s1 = sel_tab[(i + 3) % 7];
            ctrl.burst(4'(i), p, 4'h0, ~p, 4'h0);
            ctrl.burst(4'(i), q, s0, ~q, s1);
            cmp_word(4'(i), 1'b0, merge(p, q, s0, w), m);
            cmp_word(4'(i), 1'b1, merge(~p, ~q, s1, w), m);
         end
      end
      rd(8'h14, cnt, rr);
      wr(8'h00, 32'h3);
      ctrl.burst(4'h5, 36'h1_1111_1111, 4'h0, 36'h2_2222_2222, 4'h0);
      ctrl.burst(4'h6, 36'h3_3333_3333, 4'h0, 36'h4_4444_4444, 4'h0);
      chk({31'h0, wr_buf_ready}, 32'h0);
      ctrl.burst(4'h5, 36'h5_5555_5555, 4'h0, 36'h6_6666_6666, 4'h0);
      rd(8'h04, rv, rr);
      chk(rv, 32'h21);
      wr(8'h04, 32'h1);
      rd(8'h04, rv, rr);
      chk(rv, 32'h20);
      wr(8'h00, 32'h1);
      rd(8'h14, rv, rr);
      chk(rv, cnt + 32'h2);
      chk({31'h0, wr_buf_ready}, 32'h1);
      cmp_word(4'h5, 1'b0, 36'h1_1111_1111, 36'hF_FFFF_FFFF);
      results();
   end
endmodule : testbench

// File: verilog/byte_mask_pkg.sv
/*
 * constants of the byte-lane masked double-rate write port: register offsets,
 * control and status field positions, reset values and the capture states.
 * assumes a 32-bit register bus with one aligned word per register.
 */
package byte_mask_pkg;

   // ************************************************************
   // register map (byte addresses)
   // ************************************************************
   localparam logic [7:0] CTRL_OFFS = 8'h00;
   localparam logic [7:0] STATUS_OFFS = 8'h04;
   localparam logic [7:0] RD_SEL_OFFS = 8'h08;
   localparam logic [7:0] RD_LO_OFFS = 8'h0C;
   localparam logic [7:0] RD_HI_OFFS = 8'h10;
   localparam logic [7:0] WR_COUNT_OFFS = 8'h14;

   // ************************************************************
   // field positions and reset values
   // ************************************************************
   localparam int CTRL_WIDE_BIT = 0;
   localparam int CTRL_HOLD_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h0;
   localparam int STATUS_OVF_BIT = 0;
   localparam int STATUS_BUSY_BIT = 1;
   localparam int STATUS_COUNT_LSB = 4;
   localparam int RD_SEL_WORD_BIT = 8;
   localparam logic [15:0] WR_COUNT_RESET = 16'h0000;

   // ************************************************************
   // bus answers and geometry
   // ************************************************************
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int NARROW_LANES = 2;
   localparam int BUF_DEPTH = 2;

   typedef enum logic [0:0] {
      CAP_IDLE,
      CAP_WAIT_SECOND
   } cap_state_e;

endpackage : byte_mask_pkg

// File: verilog/byte_mask_write_port.sv
/*
 * double-rate write port of a burst-of-two pipelined memory with 9-bit
 * byte-lane write masking, 18-bit or 36-bit organisation, register access
 * over an axi4-lite slave, a two-entry write buffer and the array itself.
 * assumes the main input clock and its complement arrive as pins slower
 * than aclk, so their rising edges are found after a two-stage synchroniser.
 */
// Function
// RULE1: narrow mode, both selects low: all 18 bits of the word written.
// RULE2: narrow mode, select 0 only low: bits 8..0 written, 17..9 kept.
// RULE3: narrow mode, select 1 only low: bits 17..9 written, 8..0 kept.
// RULE4: narrow mode, both selects high: that word writes nothing.
// RULE5: wide mode, all four selects low: all 36 bits written.
// RULE6: wide mode, only select 0 low: bits 8..0 written, 35..9 kept.
// RULE7: wide mode, selects 1,2,3 alone write 17..9, 26..18, 35..27.
// RULE8: wide mode, all four selects high: no array update for that word.
// RULE9: after power-up the port is deselected and idle.
// RULE10: each word of a burst uses its own select values.
// RULE11: controller should stop clocks with main equal complement, outputs high; the controller model stops both clocks low.
// RULE12: port select low at main rise starts write; word 1, address on complement.
// RULE13: selects are sampled on the same edge that captures their word.
// RULE14: each select governs only its own lane; any mix writes low-select lanes.
`timescale 1ns/1ps
module byte_mask_write_port #(
   parameter int ADDR_W = 4,
   parameter int LANES = 4,
   parameter int LANE_W = 9
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clk_en,
   // memory-side pins
   input wire logic main_clk,
   input wire logic main_clk_b,
   input wire logic write_port_select_n,
   input wire logic [LANES-1:0] byte_lane_write_select_n,
   input wire logic [ADDR_W-1:0] wr_addr,
   input wire logic [LANES*LANE_W-1:0] wr_data,
   output logic wr_buf_ready,
   // axi4-lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   localparam int DW = LANES * LANE_W;

   generate
      if (LANES != 4 || LANE_W != 9 || ADDR_W < 1 || ADDR_W > 8) begin : g_bad_param
         $error("byte_mask_write_port: needs 4 lanes of 9 bits and 1..8 address bits");
      end
   endgenerate

   // ************************************************************
   // lane mask and merge
   // ************************************************************
   // a low select opens its own lane only; narrow mode never opens lanes 2 and 3
   function automatic logic [DW-1:0] lane_mask(input logic [LANES-1:0] sel_n, input logic wide);
      logic [DW-1:0] m;
      m = '0;
      for (int i = 0; i < LANES; i++) begin
         if (!sel_n[i] && (wide || i < byte_mask_pkg::NARROW_LANES)) begin
            m[i*LANE_W +: LANE_W] = {LANE_W{1'b1}}; // RULE14
         end
      end
      return m;
   endfunction : lane_mask

   function automatic logic [DW-1:0] merge(input logic [DW-1:0] old, input logic [DW-1:0] nw,
                                           input logic [DW-1:0] m);
      return (old & ~m) | (nw & m);
   endfunction : merge

   // ************************************************************
   // pin synchronisers
   // ************************************************************
   localparam int PIN_W = 3 + LANES + ADDR_W + DW;
   logic [PIN_W-1:0] pin_s1_q;
   logic [PIN_W-1:0] pin_s2_q;
   logic main_clk_d1_q;
   logic main_clk_b_d1_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_s1_q <= '0;
         pin_s2_q <= '0;
         main_clk_d1_q <= 1'b0;
         main_clk_b_d1_q <= 1'b0;
      end else if (clk_en) begin
         pin_s1_q <= {main_clk, main_clk_b, write_port_select_n, byte_lane_write_select_n,
                      wr_addr, wr_data};
         pin_s2_q <= pin_s1_q;
         main_clk_d1_q <= pin_s2_q[PIN_W-1];
         main_clk_b_d1_q <= pin_s2_q[PIN_W-2];
      end
   end

   logic main_rise;
   logic comp_rise;
   logic port_sel_n;
   logic [LANES-1:0] sel_n;
   logic [ADDR_W-1:0] pin_addr;
   logic [DW-1:0] pin_data;
   assign main_rise = pin_s2_q[PIN_W-1] && !main_clk_d1_q;
   assign comp_rise = pin_s2_q[PIN_W-2] && !main_clk_b_d1_q;
   assign port_sel_n = pin_s2_q[PIN_W-3];
   assign sel_n = pin_s2_q[DW+ADDR_W +: LANES];
   assign pin_addr = pin_s2_q[DW +: ADDR_W];
   assign pin_data = pin_s2_q[DW-1:0];

   // ************************************************************
   // control register
   // ************************************************************
   logic wide_q;
   logic hold_q;

   // ************************************************************
   // burst capture
   // ************************************************************
   byte_mask_pkg::cap_state_e cap_state_q;
   logic [DW-1:0] first_data_q;
   logic [DW-1:0] first_mask_q;
   logic push;
   logic [2*DW+ADDR_W+2*DW-1:0] push_word;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cap_state_q <= byte_mask_pkg::CAP_IDLE; // RULE9
         first_data_q <= '0;
         first_mask_q <= '0;
      end else if (clk_en) begin
         case (cap_state_q)
            byte_mask_pkg::CAP_IDLE: begin
               if (main_rise && !port_sel_n) begin
                  first_data_q <= pin_data; // RULE12
                  first_mask_q <= lane_mask(sel_n, wide_q); // RULE13
                  cap_state_q <= byte_mask_pkg::CAP_WAIT_SECOND;
               end
            end
            byte_mask_pkg::CAP_WAIT_SECOND: begin
               if (comp_rise) begin
                  cap_state_q <= byte_mask_pkg::CAP_IDLE; // RULE12
               end
            end
            default: cap_state_q <= byte_mask_pkg::CAP_IDLE;
         endcase
      end
   end

   // second word takes its own selects on the complementary edge
   assign push = (cap_state_q == byte_mask_pkg::CAP_WAIT_SECOND) && comp_rise; // RULE10
   assign push_word = {pin_addr, first_data_q, first_mask_q, pin_data,
                       lane_mask(sel_n, wide_q)}; // RULE13

   // ************************************************************
   // two-entry write buffer and array
   // ************************************************************
   // a stalled drain (hold bit) lets the buffer fill; a burst that finds it
   // full is dropped and flagged, since the pins cannot be pushed back
   logic [$bits(push_word)-1:0] buf_q [byte_mask_pkg::BUF_DEPTH];
   logic [1:0] buf_count_q;
   logic buf_wr_ptr_q;
   logic buf_rd_ptr_q;
   logic [DW-1:0] mem_lo_q [2**ADDR_W];
   logic [DW-1:0] mem_hi_q [2**ADDR_W];
   logic buf_in_ready;
   logic buf_out_valid;
   logic pop;
   logic do_push;
   logic ovf_set;
   logic [$bits(push_word)-1:0] head;
   logic [ADDR_W-1:0] head_addr;

   assign buf_in_ready = buf_count_q != 2'(byte_mask_pkg::BUF_DEPTH);
   assign buf_out_valid = buf_count_q != 2'h0;
   assign pop = buf_out_valid && !hold_q;
   assign do_push = push && buf_in_ready;
   assign ovf_set = push && !buf_in_ready;
   assign head = buf_q[buf_rd_ptr_q];
   assign head_addr = head[4*DW +: ADDR_W];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         buf_count_q <= 2'h0;
         buf_wr_ptr_q <= 1'b0;
         buf_rd_ptr_q <= 1'b0;
         wr_buf_ready <= 1'b1;
      end else if (clk_en) begin
         if (do_push) begin
            buf_wr_ptr_q <= !buf_wr_ptr_q;
         end
         if (pop) begin
            buf_rd_ptr_q <= !buf_rd_ptr_q;
         end
         if (do_push && !pop) begin
            buf_count_q <= buf_count_q + 2'h1;
         end else if (pop && !do_push) begin
            buf_count_q <= buf_count_q - 2'h1;
         end
         wr_buf_ready <= (buf_count_q - 2'(pop) + 2'(do_push)) != 2'(byte_mask_pkg::BUF_DEPTH);
      end
   end

   always_ff @(posedge aclk) begin
      if (clk_en && do_push) begin
         buf_q[buf_wr_ptr_q] <= push_word;
      end
   end

   // an all-zero mask leaves the word untouched: no lane update at all
   always_ff @(posedge aclk) begin
      if (clk_en && pop) begin
         mem_lo_q[head_addr] <= merge(mem_lo_q[head_addr], head[3*DW +: DW],
                                      head[2*DW +: DW]); // RULE1 RULE2 RULE3 RULE4
         mem_hi_q[head_addr] <= merge(mem_hi_q[head_addr], head[DW +: DW],
                                      head[0 +: DW]); // RULE5 RULE6 RULE7 RULE8
      end
   end

   // ************************************************************
   // axi4-lite slave
   // ************************************************************
   logic aw_got_q;
   logic w_got_q;
   logic [7:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic ovf_q;
   logic [15:0] wr_count_q;
   logic [8:0] rd_sel_q;
   logic wr_fire;
   logic ovf_clr;

   assign wr_fire = aw_got_q && w_got_q && !s_axi_bvalid;
   assign ovf_clr = wr_fire && aw_addr_q == byte_mask_pkg::STATUS_OFFS && w_strb_q[0]
                    && w_data_q[byte_mask_pkg::STATUS_OVF_BIT];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q <= 32'h00000000;
         w_strb_q <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= byte_mask_pkg::RESP_OKAY;
      end else if (clk_en) begin
         s_axi_awready <= !aw_got_q && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready <= !w_got_q && !(s_axi_wvalid && s_axi_wready);
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            if (aw_addr_q == byte_mask_pkg::CTRL_OFFS || aw_addr_q == byte_mask_pkg::STATUS_OFFS
                || aw_addr_q == byte_mask_pkg::RD_SEL_OFFS) begin
               s_axi_bresp <= byte_mask_pkg::RESP_OKAY;
            end else begin
               s_axi_bresp <= byte_mask_pkg::RESP_SLVERR;
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wide_q <= byte_mask_pkg::CTRL_RESET[byte_mask_pkg::CTRL_WIDE_BIT];
         hold_q <= byte_mask_pkg::CTRL_RESET[byte_mask_pkg::CTRL_HOLD_BIT];
         rd_sel_q <= 9'h000;
      end else if (clk_en && wr_fire) begin
         if (aw_addr_q == byte_mask_pkg::CTRL_OFFS && w_strb_q[0]) begin
            wide_q <= w_data_q[byte_mask_pkg::CTRL_WIDE_BIT];
            hold_q <= w_data_q[byte_mask_pkg::CTRL_HOLD_BIT];
         end else if (aw_addr_q == byte_mask_pkg::RD_SEL_OFFS) begin
            if (w_strb_q[0]) begin
               rd_sel_q[7:0] <= w_data_q[7:0];
            end
            if (w_strb_q[1]) begin
               rd_sel_q[8] <= w_data_q[byte_mask_pkg::RD_SEL_WORD_BIT];
            end
         end
      end
   end

   // set wins over a software clear in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ovf_q <= 1'b0;
         wr_count_q <= byte_mask_pkg::WR_COUNT_RESET;
      end else if (clk_en) begin
         if (ovf_set) begin
            ovf_q <= 1'b1;
         end else if (ovf_clr) begin
            ovf_q <= 1'b0;
         end
         if (pop) begin
            wr_count_q <= wr_count_q + 16'h0001;
         end
      end
   end

   logic [DW-1:0] rd_word;
   logic [ADDR_W-1:0] rd_index;
   assign rd_index = rd_sel_q[ADDR_W-1:0];
   assign rd_word = rd_sel_q[8] ? mem_hi_q[rd_index] : mem_lo_q[rd_index];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= byte_mask_pkg::RESP_OKAY;
      end else if (clk_en) begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= byte_mask_pkg::RESP_OKAY;
            s_axi_rdata <= 32'h00000000;
            if (s_axi_araddr == byte_mask_pkg::CTRL_OFFS) begin
               s_axi_rdata[byte_mask_pkg::CTRL_WIDE_BIT] <= wide_q;
               s_axi_rdata[byte_mask_pkg::CTRL_HOLD_BIT] <= hold_q;
            end else if (s_axi_araddr == byte_mask_pkg::STATUS_OFFS) begin
               s_axi_rdata[byte_mask_pkg::STATUS_OVF_BIT] <= ovf_q;
               s_axi_rdata[byte_mask_pkg::STATUS_BUSY_BIT] <=
                  cap_state_q != byte_mask_pkg::CAP_IDLE;
               s_axi_rdata[byte_mask_pkg::STATUS_COUNT_LSB +: 2] <= buf_count_q;
            end else if (s_axi_araddr == byte_mask_pkg::RD_SEL_OFFS) begin
               s_axi_rdata[8:0] <= rd_sel_q;
            end else if (s_axi_araddr == byte_mask_pkg::RD_LO_OFFS) begin
               s_axi_rdata <= rd_word[31:0];
            end else if (s_axi_araddr == byte_mask_pkg::RD_HI_OFFS) begin
               s_axi_rdata[DW-33:0] <= rd_word[DW-1:32];
            end else if (s_axi_araddr == byte_mask_pkg::WR_COUNT_OFFS) begin
               s_axi_rdata[15:0] <= wr_count_q;
            end else begin
               s_axi_rresp <= byte_mask_pkg::RESP_SLVERR;
            end
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule : byte_mask_write_port
